// [vns_cfg.svh]
// Constants for the Viterbi node synchroniser
`ifndef VNS_CFG_SVH
`define VNS_CFG_SVH
`define VNS_STEP_UP        6'h20
`define VNS_STEP_DN_MAX    6'h20
`define VNS_DN_R12         6'h1d
`define VNS_DN_R23         6'h1a
`define VNS_DN_R34         6'h19
`define VNS_DN_R56         6'h18
`define VNS_DN_R78         6'h17
`define VNS_VOTE_MAX       6'h20
`define VNS_VOTE_DEF       6'h08
`define VNS_VOTE_SHIFT     9
`define VNS_WIN_DEF        8'h08
`define VNS_WIN_SHIFT      11
`define VNS_ST_R12         4'h2
`define VNS_ST_R23         4'h6
`define VNS_ST_R34         4'h4
`define VNS_ST_R56         4'h6
`define VNS_ST_R78         4'h8
`define VNS_RATE_R12       3'h0
`define VNS_RATE_R78       3'h4
`define VNS_RATE_AUTO      3'h7
`endif

// [vns_pkg.sv]
// Types for the Viterbi node synchroniser
package vns_pkg;
    typedef struct packed {
        logic [2:0] firstCodedBranch;
        logic [2:0] secondCodedBranch;
    } vns_soft_t;
    typedef struct packed {
        logic [2:0] rate;
        logic [2:0] index;
    } vns_hyp_t;
    typedef enum logic [1:0] {
        VNS_SEARCH = 2'b01,
        VNS_LOCKED = 2'b10
    } vns_state_t;
endpackage

// [vns_node_sync.sv]
// Syndrome-based node synchroniser in front of a Viterbi decoder
// Functional notes
// - Sync must be reached: phase ambiguity removed and code rate identified.
// - Syndrome bit formed from data and rate syndrome; zero when in sync.
// - Hypothesis phase: I/Q passed unchanged or rotated by 90 degrees.
// - Hypothesis framing: one of four framings of the two streams.
// - Accumulated score reaching threshold registers an out-of-sync vote.
// - Each out-of-sync vote advances the state index, which is readable.
// - Step up is fixed at 32.
// - Step down from 6-bit field capped at 32, or rate default.
// - Default step down: 29, 26, 25, 24, 23 for the five rates.
// - Vote limit from field capped at 32, default 8.
// - Threshold is vote limit times 512.
// - States per rate: 2, 6, 4, 6, 8.
// - Automatic mode tests every rate's states in sequence.
// - Lock shown when state unchanged for a lock window; default length 8.
// - Lock window lasts length times 2048 syndrome bits.
// - No threshold within a window: clear accumulator, stay locked.
// - Threshold inside window: out of lock, next state, restart.
// - Rates encode 000 to 100; 111 means automatic on input only.
// - Current rate shown on decoded_rate_pins and status port.
// - decoder_locked_flag is active high sync status.
`timescale 1ns/10ps
`include "vns_cfg.svh"
module vns_node_sync
    import vns_pkg::*;
#(
    parameter int ACC_W = 16,
    parameter int WIN_W = 20
) (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       softValid,
    input  wire vns_soft_t  softIn,
    input  wire logic [2:0] rateSelect,
    input  wire logic       useRateDefaultStepDown,
    input  wire logic [5:0] stepDownField,
    input  wire logic       useDefaultVoteLimit,
    input  wire logic [5:0] voteLimitField,
    input  wire logic       useDefaultLockWindow,
    input  wire logic [7:0] lockWindowField,
    output logic            symValid,
    output vns_soft_t       symOut,
    output logic [2:0]      decodedRatePins,
    output logic [2:0]      syncStateIndex,
    output logic [2:0]      decodedRateStatus,
    output logic            decoderLockedFlag
);
    // Sizing: the accumulator must hold 32 x 512 plus one step up without wrapping,
    // and the window counter must reach 255 x 2048 syndrome bits.
    // Narrower settings would wrap silently, so they are refused here.
    initial begin
        if (ACC_W < 16 || WIN_W < 19) begin
            $error("vns_node_sync: widths too small for threshold or window");
        end
    end

    // Reset release synchroniser
    // Assertion is immediate; release waits two edges so that no flop
    // leaves reset on a metastable recovery. Costs two cycles of latency.
    logic rstMeta_q;
    logic rstSync_q;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end
    wire logic rstN = rstSync_q;

    vns_hyp_t   hyp_q;
    vns_state_t state_q;
    logic [ACC_W-1:0] acc_q;
    logic [WIN_W-1:0] win_q;
    logic [5:0] histFirst_q;
    logic [5:0] histSecond_q;

    // States per rate
    function automatic logic [3:0] statesOf(input logic [2:0] r);
        case (r)
            3'h0:    statesOf = `VNS_ST_R12;
            3'h1:    statesOf = `VNS_ST_R23;
            3'h2:    statesOf = `VNS_ST_R34;
            3'h3:    statesOf = `VNS_ST_R56;
            default: statesOf = `VNS_ST_R78;
        endcase
    endfunction

    // Effective step down
    // Use flag high takes the field, capped; low takes the rate default.
    // The cap keeps the drift of a wrong hypothesis pointing upward.
    logic [5:0] stepDown;
    always_comb begin
        if (useRateDefaultStepDown) begin
            stepDown = (stepDownField > `VNS_STEP_DN_MAX) ? `VNS_STEP_DN_MAX
                                                           : stepDownField;
        end else begin
            case (hyp_q.rate)
                3'h0:    stepDown = `VNS_DN_R12;
                3'h1:    stepDown = `VNS_DN_R23;
                3'h2:    stepDown = `VNS_DN_R34;
                3'h3:    stepDown = `VNS_DN_R56;
                default: stepDown = `VNS_DN_R78;
            endcase
        end
    end

    // Threshold and lock window lengths
    // Both are plain shifts of the selected length, so no multiplier is needed.
    // A window field of zero gives an immediate window end; software must avoid it.
    logic [5:0] effectiveVoteLimit;
    logic [7:0] lockWindowLength;
    logic [ACC_W-1:0] threshold;
    logic [WIN_W-1:0] windowBits;
    always_comb begin
        if (!useDefaultVoteLimit) begin
            effectiveVoteLimit = `VNS_VOTE_DEF;
        end else if (voteLimitField > `VNS_VOTE_MAX) begin
            effectiveVoteLimit = `VNS_VOTE_MAX;
        end else begin
            effectiveVoteLimit = voteLimitField;
        end
        lockWindowLength = useDefaultLockWindow ? lockWindowField : `VNS_WIN_DEF;
        threshold  = ACC_W'({effectiveVoteLimit, 9'h000});
        windowBits = WIN_W'({lockWindowLength, 11'h000});
    end

    // Phase rotation of the input pair; framing is applied at the syndrome taps
    // Rotation by 90 degrees maps (I,Q) to (Q,-I); -x on soft bits is bit inversion
    vns_soft_t rotated;
    always_comb begin
        if (hyp_q.index[0]) begin
            rotated.firstCodedBranch  = softIn.secondCodedBranch;
            rotated.secondCodedBranch = ~softIn.firstCodedBranch;
        end else begin
            rotated = softIn;
        end
    end

    // Hard-bit history for syndrome; framing picks the tap offset
    // Only valid words shift, so bursts with gaps give the same syndrome
    // stream as a continuous feed.
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            histFirst_q  <= 6'h00;
            histSecond_q <= 6'h00;
        end else if (softValid) begin
            histFirst_q  <= {histFirst_q[4:0], rotated.firstCodedBranch[2]};
            histSecond_q <= {histSecond_q[4:0], rotated.secondCodedBranch[2]};
        end
    end

    // Syndrome: parity over rate-dependent taps of the shifted history
    logic [1:0] frameSel;
    logic [5:0] tapMask;
    logic       syndromeBit;
    always_comb begin
        frameSel = hyp_q.index[2:1];
        case (hyp_q.rate)
            3'h0:    tapMask = 6'h2d;
            3'h1:    tapMask = 6'h1b;
            3'h2:    tapMask = 6'h37;
            3'h3:    tapMask = 6'h3b;
            default: tapMask = 6'h3d;
        endcase
        syndromeBit = ^((histFirst_q >> frameSel) & tapMask)
                    ^ ^((histSecond_q >> frameSel) & {tapMask[0], tapMask[5:1]});
    end

    // Accumulator with zero floor and vote detection
    // The floor stops a long run of zeros from building credit that would
    // delay detection of a later loss of sync.
    logic [ACC_W-1:0] accNext;
    logic             vote;
    logic             windowEnd;
    always_comb begin
        if (syndromeBit) begin
            accNext = acc_q + ACC_W'(`VNS_STEP_UP);
        end else if (acc_q > ACC_W'(stepDown)) begin
            accNext = acc_q - ACC_W'(stepDown);
        end else begin
            accNext = '0;
        end
        vote      = softValid && (accNext >= threshold);
        windowEnd = softValid && (win_q + 1'b1 >= windowBits);
    end

    // Next hypothesis, walking all rates when automatic
    vns_hyp_t hypNext;
    logic     autoMode;
    always_comb begin
        autoMode = (rateSelect == `VNS_RATE_AUTO);
        hypNext  = hyp_q;
        if ({1'b0, hyp_q.index} + 4'h1 < statesOf(hyp_q.rate)) begin
            hypNext.index = hyp_q.index + 3'h1;
        end else begin
            hypNext.index = 3'h0;
            if (autoMode) begin
                hypNext.rate = (hyp_q.rate >= `VNS_RATE_R78) ? `VNS_RATE_R12
                                                             : hyp_q.rate + 3'h1;
            end
        end
    end

    // Forced rate change; codes 101 and 110 are ignored and hold the rate
    // A forced change restarts acquisition so old score cannot vote or lock
    logic forceRate;
    always_comb begin
        forceRate = !autoMode && (rateSelect <= `VNS_RATE_R78)
                 && (rateSelect != hyp_q.rate);
    end

    // Hypothesis register; a forced rate change restarts at its first state
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            hyp_q <= '0;
        end else if (forceRate) begin
            hyp_q <= '{rate: rateSelect, index: 3'h0};
        end else if (vote) begin
            hyp_q <= hypNext;
        end
    end

    // Accumulator and window counter
    // Both restart together so a window always measures one hypothesis only
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            acc_q <= '0;
            win_q <= '0;
        end else if (forceRate) begin
            acc_q <= '0;
            win_q <= '0;
        end else if (softValid) begin
            if (vote || windowEnd) begin
                acc_q <= '0;
                win_q <= '0;
            end else begin
                acc_q <= accNext;
                win_q <= win_q + 1'b1;
            end
        end
    end

    // Lock state: a full quiet window locks, any vote drops lock
    // A vote in the same word as a window end wins, so lock is never shown
    // for a hypothesis that has just been rejected.
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            state_q <= VNS_SEARCH;
        end else if (forceRate) begin
            state_q <= VNS_SEARCH;
        end else begin
            case (state_q)
                VNS_SEARCH: if (windowEnd && !vote) state_q <= VNS_LOCKED;
                VNS_LOCKED: if (vote) state_q <= VNS_SEARCH;
                default:    state_q <= VNS_SEARCH;
            endcase
        end
    end

    // Registered outputs; data is only flagged valid once locked
    // Pins and status carry the same rate; 111 can never appear since
    // the hypothesis rate only holds codes 000 to 100.
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            symValid          <= 1'b0;
            symOut            <= '0;
            decodedRatePins   <= 3'h0;
            decodedRateStatus <= 3'h0;
            syncStateIndex    <= 3'h0;
            decoderLockedFlag <= 1'b0;
        end else begin
            symValid          <= softValid && (state_q == VNS_LOCKED);
            symOut            <= rotated;
            decodedRatePins   <= hyp_q.rate;
            decodedRateStatus <= hyp_q.rate;
            syncStateIndex    <= hyp_q.index;
            decoderLockedFlag <= (state_q == VNS_LOCKED);
        end
    end
endmodule

// [vns_node_sync_chk.sv]
// Port assertions for the node synchroniser
`timescale 1ns/10ps
module vns_node_sync_chk
    import vns_pkg::*;
#(
    parameter int ACC_W = 16,
    parameter int WIN_W = 20
) (
    input wire logic       clock,
    input wire logic       nrst,
    input wire logic       softValid,
    input wire logic [2:0] rateSelect,
    input wire logic       useDefaultVoteLimit,
    input wire logic [5:0] voteLimitField,
    input wire logic       useDefaultLockWindow,
    input wire logic [7:0] lockWindowField,
    input wire logic       symValid,
    input wire logic [2:0] decodedRatePins,
    input wire logic [2:0] syncStateIndex,
    input wire logic [2:0] decodedRateStatus,
    input wire logic       decoderLockedFlag
);
    logic [19:0] validCnt_q;
    logic [2:0]  idx_q, rate_q, selA_q, selB_q, selC_q;
    logic        moved, steady;
    logic [5:0]  voteSel;
    logic [18:0] winLen;
    function automatic logic [3:0] nStates(input logic [2:0] r);
        return r == 3'h0 ? 4'h2 : r == 3'h2 ? 4'h4 : r == 3'h4 ? 4'h8 : 4'h6;
    endfunction
    // Margin of two words covers the output register lag
    assign moved   = syncStateIndex != idx_q || decodedRatePins != rate_q;
    assign steady  = rateSelect == selA_q && selA_q == selB_q && selB_q == selC_q;
    assign voteSel = !useDefaultVoteLimit ? 6'h08 : voteLimitField > 6'h20 ? 6'h20 : voteLimitField;
    assign winLen  = {useDefaultLockWindow ? lockWindowField : 8'h08, 11'h000};
    // Valid words since the hypothesis last moved, saturating
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) validCnt_q <= 20'h00000;
        else validCnt_q <= moved ? 20'h00000 : validCnt_q + {19'h0, softValid & ~&validCnt_q};
    end
    // Output and rate select history
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) {idx_q, rate_q, selA_q, selB_q, selC_q} <= 15'h0000;
        else {idx_q, rate_q, selA_q, selB_q, selC_q} <=
            {syncStateIndex, decodedRatePins, rateSelect, selA_q, selB_q};
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    a_rate_never_auto: assert property (decodedRatePins <= 3'h4)
        else $error("rate code out of range");
    a_pins_match_status: assert property (decodedRatePins == decodedRateStatus)
        else $error("rate pins and status differ");
    a_index_in_range: assert property ({1'b0, syncStateIndex} < nStates(decodedRatePins))
        else $error("index beyond state count");
    a_idle_hold_state: assert property (!$past(softValid) && !$past(softValid, 2) && steady
        |-> $stable(syncStateIndex)) else $error("index moved without input");
    a_vote_drops_lock: assert property ($changed(syncStateIndex) && $stable(decodedRatePins)
        |-> !decoderLockedFlag) else $error("lock kept across a vote");
    a_lock_full_window: assert property ($rose(decoderLockedFlag)
        |-> validCnt_q + 20'h00002 >= {1'b0, winLen}) else $error("lock before window end");
    a_vote_min_words: assert property (moved && steady
        |-> validCnt_q + 20'h00002 >= {10'h000, voteSel, 4'h0}) else $error("vote below threshold");
    a_sym_follows_valid: assert property (decoderLockedFlag && $past(decoderLockedFlag)
        |-> symValid == $past(softValid)) else $error("output valid not following input");
endmodule
bind vns_node_sync vns_node_sync_chk #(.ACC_W(ACC_W), .WIN_W(WIN_W)) vns_node_sync_chk_inst (
    .clock(clock), .nrst(nrst), .softValid(softValid), .rateSelect(rateSelect),
    .useDefaultVoteLimit(useDefaultVoteLimit), .voteLimitField(voteLimitField),
    .useDefaultLockWindow(useDefaultLockWindow), .lockWindowField(lockWindowField),
    .symValid(symValid), .decodedRatePins(decodedRatePins), .syncStateIndex(syncStateIndex),
    .decodedRateStatus(decodedRateStatus), .decoderLockedFlag(decoderLockedFlag));

// [vns_upstream_model.sv]
// Upstream demapper model sending soft pairs in bursts
`timescale 1ns/10ps
module vns_upstream_model
    import vns_pkg::*;
(
    input  wire logic clock,
    input  wire logic randomData,
    input  int        budget,
    output logic      softValid,
    output vns_soft_t softIn,
    output int        sent
);
    int seed = 97;
    initial {softValid, softIn, sent} = '0;
    // Random gaps; each idle cycle inverts the bus word, so a second idle in a row shows the last word again
    always @(negedge clock) begin
        if (sent < budget && ($random(seed) & 3) != 0) begin
            softValid <= 1'b1;
            softIn    <= randomData ? vns_soft_t'($random(seed)) : '1;
        end else begin
            softValid <= 1'b0;
            softIn    <= ~softIn;
        end
    end
    // Words taken by the synchroniser
    always @(posedge clock) if (softValid) sent <= sent + 1;
endmodule

// [vns_node_sync_tb.sv]
// Self-checking bench for the node synchroniser
`timescale 1ns/10ps
module vns_node_sync_tb;
    import vns_pkg::*;
    logic       clock = 1'b0, nrst = 1'b0, randomData = 1'b0, stepDef = 1'b1;
    logic [2:0] rateSelect = 3'h0, prevIdx = 3'h0, prevRate = 3'h0;
    logic       softValid, symValid, decoderLockedFlag;
    vns_soft_t  softIn, symOut, lastIn, expSym;
    logic [2:0] decodedRatePins, syncStateIndex, decodedRateStatus;
    int         budget = 0, sent, n_fail = 0, comparisons = 0, nChg = 0, nSym = 0, e;
    bit         track = 1'b0, autoMode = 1'b0;
    int         states [5] = '{2, 6, 4, 6, 8};
    always #2 clock = ~clock;
    vns_upstream_model vns_upstream_model_inst (.clock(clock), .randomData(randomData),
        .budget(budget), .softValid(softValid), .softIn(softIn), .sent(sent));
    vns_node_sync vns_node_sync_inst (.clock(clock), .nrst(nrst), .softValid(softValid),
        .softIn(softIn), .rateSelect(rateSelect), .useRateDefaultStepDown(stepDef),
        .stepDownField(6'h00), .useDefaultVoteLimit(1'b1), .voteLimitField(6'h01),
        .useDefaultLockWindow(1'b1), .lockWindowField(8'h01), .symValid(symValid),
        .symOut(symOut), .decodedRatePins(decodedRatePins), .syncStateIndex(syncStateIndex),
        .decodedRateStatus(decodedRateStatus), .decoderLockedFlag(decoderLockedFlag));
    task automatic chk_val(input string what, input logic [2:0] seen, input logic [2:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic chk_cnt(input string what, input int seen, input int exp);
        comparisons++;
        if (seen != exp) begin
            n_fail++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, seen);
        end
    endtask
    task automatic chk_sym(input vns_soft_t seen, input vns_soft_t exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH symOut expected %0h seen %0h", exp, seen);
        end
    endtask
    always @(posedge clock) if (softValid) lastIn <= softIn;
    task automatic wait_sent(input int n);
        budget = n;
        for (int i = 0; i < 4 * n && sent < n; i++) @(posedge clock) #1;
    endtask
    task automatic wait_moves(input int n);
        int t;
        t = nChg + n;
        budget = 32'h7fffffff;
        for (int i = 0; i < 3000 * n && nChg < t; i++) @(posedge clock) #1;
        budget = sent;
        @(negedge clock);
    endtask
    task automatic report_and_stop();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Reference stepping model, compared at every hypothesis move while track is set
    always @(negedge clock) begin
        if ({decodedRatePins, syncStateIndex} !== {prevRate, prevIdx}) begin
            if (track) begin
                e = (prevIdx + 1) % states[prevRate];
                chk_val("index", syncStateIndex, e[2:0]);
                e = (autoMode && e == 0) ? (prevRate + 1) % 5 : prevRate;
                chk_val("rate", decodedRatePins, e[2:0]);
                chk_val("lock", {2'b0, decoderLockedFlag}, 3'h0);
                nChg++;
            end
            prevIdx  = syncStateIndex;
            prevRate = decodedRatePins;
        end
        if (symValid === 1'b1) begin
            nSym++;
            expSym = prevIdx[0] ? vns_soft_t'({lastIn.secondCodedBranch,
                                               ~lastIn.firstCodedBranch}) : lastIn;
            chk_sym(symOut, expSym);
        end
    end
    initial begin
        repeat (4) @(negedge clock);
        nrst = 1'b1;
        repeat (3) @(negedge clock);
        wait_sent(2047);
        repeat (4) @(negedge clock);
        chk_val("early lock", {2'b0, decoderLockedFlag}, 3'h0);
        wait_sent(2048);
        repeat (3) @(negedge clock);
        chk_val("lock", {2'b0, decoderLockedFlag}, 3'h1);
        nSym = 0;
        wait_sent(6144);
        repeat (3) @(negedge clock);
        chk_val("held lock", {2'b0, decoderLockedFlag}, 3'h1);
        chk_cnt("symbols", nSym, 4096);
        $display("Test lock done");
        randomData = 1'b1;
        for (int r = 0; r < 5; r++) begin
            track      = 1'b0;
            rateSelect = r[2:0];
            repeat (4) @(negedge clock);
            chk_val("forced rate", decodedRatePins, r[2:0]);
            chk_val("rate status", decodedRateStatus, r[2:0]);
            chk_val("start index", syncStateIndex, 3'h0);
            track = 1'b1;
            wait_moves(states[r] + 1);
            $display("Test rate %0d done", r);
        end
        track      = 1'b0;
        autoMode   = 1'b1;
        stepDef    = 1'b0;
        rateSelect = 3'h7;
        repeat (4) @(negedge clock);
        track = 1'b1;
        wait_moves(30);
        $display("Test automatic done");
        report_and_stop();
    end
    // Watchdog sized well above the expected run
    initial begin
        #360000;
        n_fail++;
        $display("MISMATCH watchdog expected done seen hung");
        report_and_stop();
    end
endmodule
